// *** logic/psfb_flag_bank.v ***
// Special relay flag bank with APB register access
//
// Summary of operation
// - Run flag on only in run mode
// - Pause flag on in pause mode
// - Debug flag on in debug mode
// - One flag always one, one always zero
// - Toggle flag inverts at every scan end
// - Step flag during single step debug run
// - Breakpoint flag during breakpoint debug run
// - Scan-run flag during scan debug run
// - Bit-match flag during bit-match debug run
// - Word-match flag during word-match debug run
// - Positions between word-match and fatal flags unused, zero
// - Fatal flag when fatal error detected
// - Ordinary flag when non-fatal error detected
// - Watchdog flag when scan watchdog reports
// - I/O error flag is OR of module bits
// - Battery flag when battery voltage low
// - Fuse flag when output fuse blown
// - Report overrun past limit, keep running
`include "psfb_regs.vh"

module psfb_flag_bank #(
    parameter MS_CYCLES = `PSFB_MS_NS / `PSFB_CLK_NS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PSFB_ADDR_W-1:0] paddr,
    input wire [`PSFB_DATA_W-1:0] pwdata,
    output reg [`PSFB_DATA_W-1:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [`PSFB_MODE_W-1:0] mode_sel,
    input wire [`PSFB_DBG_W-1:0] dbg_run_sel,
    input wire scan_end,
    input wire fatal_err,
    input wire ordinary_err,
    input wire [`PSFB_IO_W-1:0] io_err,
    input wire battery_low,
    input wire fuse_blown
);

localparam ST_IDLE = 2'b01;
localparam ST_ACC = 2'b10;
localparam SYNC_W = `PSFB_MODE_W + `PSFB_DBG_W + 5 + `PSFB_IO_W;

wire [SYNC_W-1:0] sync_q;
wire [`PSFB_MODE_W-1:0] mode_s;
wire [`PSFB_DBG_W-1:0] dbg_s;
wire scan_s;
wire fatal_s;
wire ordin_s;
wire batt_s;
wire fuse_s;
wire [`PSFB_IO_W-1:0] io_s;
wire [`PSFB_MS_W-1:0] scan_ms;
wire overrun;

reg scan_d_r;
reg scan_pulse_r;
reg first_scan_r;
reg toggle_r;
reg [3:0] mode_flags_r;
reg [4:0] dbg_flags_r;
reg fatal_r;
reg ordin_r;
reg batt_r;
reg fuse_r;
reg [`PSFB_IO_W-1:0] io_r;
reg io_any_r;
reg wdog_r;
reg wdog_nxt;
reg [`PSFB_MS_W-1:0] wdlim_r;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [`PSFB_DATA_W-1:0] rd_word;
reg rd_err;
reg wr_err;
reg clr_wdog;
reg wr_lim;

// Pin inputs cross into the bus clock
psfb_sync #(
    .WIDTH(SYNC_W)
) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({mode_sel, dbg_run_sel, scan_end, fatal_err, ordinary_err, battery_low, fuse_blown, io_err}),
    .q(sync_q)
);

assign mode_s = sync_q[SYNC_W-1 -: `PSFB_MODE_W];
assign dbg_s = sync_q[SYNC_W-`PSFB_MODE_W-1 -: `PSFB_DBG_W];
assign scan_s = sync_q[`PSFB_IO_W+4];
assign fatal_s = sync_q[`PSFB_IO_W+3];
assign ordin_s = sync_q[`PSFB_IO_W+2];
assign batt_s = sync_q[`PSFB_IO_W+1];
assign fuse_s = sync_q[`PSFB_IO_W];
assign io_s = sync_q[`PSFB_IO_W-1:0];

psfb_scan_wdog #(
    .MS_CYCLES(MS_CYCLES)
) u_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .scan_end(scan_pulse_r),
    .limit(wdlim_r),
    .scan_ms_r(scan_ms),
    .overrun_r(overrun)
);

// Address match, shared by read mux and write commit
function addr_is;
    input [`PSFB_ADDR_W-1:0] a;
    input [`PSFB_ADDR_W-1:0] off;
    begin
        addr_is = (a == off);
    end
endfunction

// Scan boundary is the rising edge of the synchronised strobe
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        scan_d_r <= 1'b0;
        scan_pulse_r <= 1'b0;
    end
    else
    begin
        scan_d_r <= scan_s;
        scan_pulse_r <= scan_s & ~scan_d_r;
    end
end

// Flags refresh once per scan so the program sees a stable image
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        first_scan_r <= 1'b1;
        toggle_r <= 1'b0;
        mode_flags_r <= 4'h0;
        dbg_flags_r <= 5'h00;
        fatal_r <= 1'b0;
        ordin_r <= 1'b0;
        batt_r <= 1'b0;
        fuse_r <= 1'b0;
        io_r <= 32'h00000000;
        io_any_r <= 1'b0;
    end
    else if (scan_pulse_r)
    begin
        first_scan_r <= 1'b0;
        toggle_r <= ~toggle_r;
        // Mode code is a single field, so only one flag can be set
        mode_flags_r[`PSFB_B_RUN] <= (mode_s == `PSFB_MODE_RUN);
        mode_flags_r[`PSFB_B_PROG] <= (mode_s == `PSFB_MODE_PROG);
        mode_flags_r[`PSFB_B_PAUSE] <= (mode_s == `PSFB_MODE_PAUSE);
        mode_flags_r[`PSFB_B_DEBUG] <= (mode_s == `PSFB_MODE_DEBUG);
        // Debug run kinds only count while in debug mode
        dbg_flags_r[`PSFB_B_STEP] <= (mode_s == `PSFB_MODE_DEBUG) && (dbg_s == `PSFB_DBG_STEP);
        dbg_flags_r[`PSFB_B_BRK] <= (mode_s == `PSFB_MODE_DEBUG) && (dbg_s == `PSFB_DBG_BRK);
        dbg_flags_r[`PSFB_B_SCANRUN] <= (mode_s == `PSFB_MODE_DEBUG) && (dbg_s == `PSFB_DBG_SCAN);
        dbg_flags_r[`PSFB_B_BITMATCH] <= (mode_s == `PSFB_MODE_DEBUG) && (dbg_s == `PSFB_DBG_BITMATCH);
        dbg_flags_r[`PSFB_B_WORDMATCH] <= (mode_s == `PSFB_MODE_DEBUG) && (dbg_s == `PSFB_DBG_WORDMATCH);
        fatal_r <= fatal_s;
        ordin_r <= ordin_s;
        io_r <= io_s;
        io_any_r <= |io_s;
        batt_r <= batt_s;
        fuse_r <= fuse_s;
    end
end

// Watchdog flag is sticky; a new overrun beats a clear
always @*
begin
    wdog_nxt = wdog_r;
    if (clr_wdog)
        wdog_nxt = 1'b0;
    if (overrun)
        wdog_nxt = 1'b1;
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        wdog_r <= 1'b0;
        wdlim_r <= `PSFB_WDLIM_RST;
    end
    else
    begin
        wdog_r <= wdog_nxt;
        // Range is software's duty, value taken as written
        if (wr_lim)
            wdlim_r <= pwdata[`PSFB_MS_W-1:0];
    end
end

// Read image; unused positions stay zero
always @*
begin
    rd_word = 32'h00000000;
    rd_err = 1'b0;
    wr_err = 1'b0;
    if (addr_is(paddr, `PSFB_OFF_MODE))
    begin
        rd_word[3:0] = mode_flags_r;
        rd_word[`PSFB_B_ON] = 1'b1;
        rd_word[`PSFB_B_OFF] = 1'b0;
        rd_word[`PSFB_B_FIRST_ON] = first_scan_r;
        rd_word[`PSFB_B_FIRST_OFF] = ~first_scan_r;
        rd_word[`PSFB_B_TOGGLE] = toggle_r;
        wr_err = 1'b1;
    end
    else if (addr_is(paddr, `PSFB_OFF_DBGERR))
    begin
        rd_word[4:0] = dbg_flags_r;
        rd_word[`PSFB_B_FATAL] = fatal_r;
        rd_word[`PSFB_B_ORDIN] = ordin_r;
        rd_word[`PSFB_B_WDOG] = wdog_r;
        rd_word[`PSFB_B_IOERR] = io_any_r;
        rd_word[`PSFB_B_BATT] = batt_r;
        rd_word[`PSFB_B_FUSE] = fuse_r;
        wr_err = 1'b1;
    end
    else if (addr_is(paddr, `PSFB_OFF_IOERR))
    begin
        rd_word = io_r;
        wr_err = 1'b1;
    end
    else if (addr_is(paddr, `PSFB_OFF_WDLIM))
        rd_word[`PSFB_MS_W-1:0] = wdlim_r;
    else if (addr_is(paddr, `PSFB_OFF_SCANT))
    begin
        rd_word[`PSFB_MS_W-1:0] = scan_ms;
        wr_err = 1'b1;
    end
    else if (addr_is(paddr, `PSFB_OFF_CTRL))
        rd_word = 32'h00000000;
    else
    begin
        rd_err = 1'b1;
        wr_err = 1'b1;
    end
end

// Commit strobes only at the edge that samples pready
always @*
begin
    clr_wdog = 1'b0;
    wr_lim = 1'b0;
    if (state_r == ST_ACC && psel && penable && pwrite && !wr_err)
    begin
        clr_wdog = addr_is(paddr, `PSFB_OFF_CTRL) && pwdata[`PSFB_B_CLR_WDOG];
        wr_lim = addr_is(paddr, `PSFB_OFF_WDLIM);
    end
end

// One wait state keeps every bus output registered
always @*
begin
    case (state_r)
        ST_IDLE:
        begin
            if (psel && penable)
                state_nxt = ST_ACC;
            else
                state_nxt = ST_IDLE;
        end
        ST_ACC:
            state_nxt = ST_IDLE;
        default:
            state_nxt = ST_IDLE;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_r <= ST_IDLE;
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        state_r <= state_nxt;
        if (state_r == ST_IDLE && psel && penable)
        begin
            pready <= 1'b1;
            pslverr <= pwrite ? wr_err : rd_err;
            prdata <= pwrite ? 32'h00000000 : rd_word;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end
end

endmodule // psfb_flag_bank

// *** logic/psfb_regs.vh ***
// Register offsets, field positions and timing constants of the status flag bank
`ifndef PSFB_REGS_VH
`define PSFB_REGS_VH

`define PSFB_ADDR_W 8
`define PSFB_DATA_W 32

`define PSFB_OFF_MODE 8'h00
`define PSFB_OFF_DBGERR 8'h04
`define PSFB_OFF_IOERR 8'h08
`define PSFB_OFF_WDLIM 8'h0C
`define PSFB_OFF_SCANT 8'h10
`define PSFB_OFF_CTRL 8'h14

`define PSFB_B_RUN 0
`define PSFB_B_PROG 1
`define PSFB_B_PAUSE 2
`define PSFB_B_DEBUG 3
`define PSFB_B_ON 16
`define PSFB_B_OFF 17
`define PSFB_B_FIRST_ON 18
`define PSFB_B_FIRST_OFF 19
`define PSFB_B_TOGGLE 20

`define PSFB_B_STEP 0
`define PSFB_B_BRK 1
`define PSFB_B_SCANRUN 2
`define PSFB_B_BITMATCH 3
`define PSFB_B_WORDMATCH 4
`define PSFB_B_FATAL 16
`define PSFB_B_ORDIN 17
`define PSFB_B_WDOG 18
`define PSFB_B_IOERR 19
`define PSFB_B_BATT 20
`define PSFB_B_FUSE 21

`define PSFB_B_CLR_WDOG 0

`define PSFB_MODE_W 2
`define PSFB_MODE_PROG 2'h0
`define PSFB_MODE_RUN 2'h1
`define PSFB_MODE_PAUSE 2'h2
`define PSFB_MODE_DEBUG 2'h3

`define PSFB_DBG_W 3
`define PSFB_DBG_NONE 3'h0
`define PSFB_DBG_STEP 3'h1
`define PSFB_DBG_BRK 3'h2
`define PSFB_DBG_SCAN 3'h3
`define PSFB_DBG_BITMATCH 3'h4
`define PSFB_DBG_WORDMATCH 3'h5

`define PSFB_IO_W 32
`define PSFB_MS_W 13
`define PSFB_MS_MAX 13'h1FFF
`define PSFB_WDLIM_RST 13'h1770

`define PSFB_CLK_NS 50
`define PSFB_MS_NS 1000000

`endif

// *** logic/psfb_sync.v ***
// Two-flop synchroniser for a group of pin inputs
module psfb_sync #(
    parameter WIDTH = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta_r;

// First stage feeds only the second
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        meta_r <= {WIDTH{1'b0}};
        q <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= d;
        q <= meta_r;
    end
end

endmodule // psfb_sync

// *** logic/psfb_scan_wdog.v ***
// Scan time measurement and scan watchdog
`include "psfb_regs.vh"

module psfb_scan_wdog #(
    parameter MS_CYCLES = 20000
) (
    input wire pclk,
    input wire presetn,
    input wire scan_end,
    input wire [`PSFB_MS_W-1:0] limit,
    output reg [`PSFB_MS_W-1:0] scan_ms_r,
    output reg overrun_r
);

reg [31:0] div_r;
reg ms_tick_r;
reg [`PSFB_MS_W-1:0] cur_ms_r;
reg fired_r;

// Free running millisecond enable
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        div_r <= 32'h00000000;
        ms_tick_r <= 1'b0;
    end
    else if (div_r == MS_CYCLES - 1)
    begin
        div_r <= 32'h00000000;
        ms_tick_r <= 1'b1;
    end
    else
    begin
        div_r <= div_r + 32'h00000001;
        ms_tick_r <= 1'b0;
    end
end

// Overrun reported once per scan; scan keeps running
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cur_ms_r <= {`PSFB_MS_W{1'b0}};
        scan_ms_r <= {`PSFB_MS_W{1'b0}};
        fired_r <= 1'b0;
        overrun_r <= 1'b0;
    end
    else
    begin
        overrun_r <= 1'b0;
        if (scan_end)
        begin
            scan_ms_r <= cur_ms_r;
            cur_ms_r <= {`PSFB_MS_W{1'b0}};
            fired_r <= 1'b0;
        end
        else
        begin
            if (ms_tick_r && cur_ms_r != `PSFB_MS_MAX)
                cur_ms_r <= cur_ms_r + 13'h0001;
            if (!fired_r && cur_ms_r > limit)
            begin
                fired_r <= 1'b1;
                overrun_r <= 1'b1;
            end
        end
    end
end

endmodule // psfb_scan_wdog

// *** dv/psfb_flag_bank_monitor.sv ***
// Assertion checker for the flag bank register port
`include "psfb_regs.vh"
module psfb_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PSFB_ADDR_W-1:0] paddr,
    input wire [`PSFB_DATA_W-1:0] prdata,
    input wire pready,
    input wire pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_access_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("Access not answered after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("Ready stood longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("Error flag without ready");
    a_idle_data_zero: assert property (!pready |-> prdata == 0)
        else $error("Read data not zero outside answer");
    a_ro_write_err: assert property (
        pready && pwrite && paddr inside {8'h00, 8'h04, 8'h08, 8'h10} |-> pslverr && prdata == 0)
        else $error("Write to read-only word accepted");
    a_const_flags: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[16] && !prdata[17])
        else $error("Constant flags wrong");
    a_mode_single: assert property (pready && !pwrite && paddr == 8'h00 |-> $countones(prdata[3:0]) <= 1)
        else $error("More than one mode flag");
    a_first_pair: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[18] != prdata[19])
        else $error("First-scan flags not complementary");
    a_unused_zero: assert property (
        pready && !pwrite && paddr == 8'h04 |-> prdata[15:5] == 0 && $countones(prdata[4:0]) <= 1)
        else $error("Unused debug positions set");
endmodule // psfb_monitor

bind psfb_flag_bank psfb_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** dv/test_plc_status_flag_bank.sv ***
// Self-checking bench for the status flag bank
`include "psfb_regs.vh"
module test_plc_status_flag_bank;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, scan_end = 0, pready, pslverr, err, tog = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, io_err = 0;
    logic [1:0] mode_sel = 0;
    logic [2:0] dbg_run_sel = 0;
    logic fatal_err = 0, ordinary_err = 0, battery_low = 0, fuse_blown = 0;
    int errors = 0, check_count = 0;
    always #25 pclk = ~pclk;
    // Short millisecond so the watchdog trips within a few dozen cycles
    psfb_flag_bank #(.MS_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_sel(mode_sel), .dbg_run_sel(dbg_run_sel), .scan_end(scan_end), .fatal_err(fatal_err),
        .ordinary_err(ordinary_err), .io_err(io_err), .battery_low(battery_low), .fuse_blown(fuse_blown));
    task results;
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [32:0] g, input logic [32:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Leading edge keeps two transfers from touching psel in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
            errors++;
        psel <= 0;
        penable <= 0;
    endtask
    task scan;
        @(posedge pclk);
        scan_end <= 1;
        repeat (3) @(posedge pclk);
        scan_end <= 0;
        repeat (6) @(posedge pclk);
        tog = ~tog;
    endtask
    function logic [31:0] exp_mode(input logic [1:0] m, input logic first);
        exp_mode = 32'h0001_0000;
        exp_mode[(m < 2) ? 1 - m : m] = 1;
        exp_mode[18] = first;
        exp_mode[19] = !first;
        exp_mode[20] = tog;
    endfunction
    function logic [31:0] exp_dbg;
        exp_dbg = 32'h0;
        if (mode_sel == 3 && dbg_run_sel >= 1 && dbg_run_sel <= 5)
            exp_dbg[dbg_run_sel - 1] = 1;
        exp_dbg[21:16] = {fuse_blown, battery_low, |io_err, 1'b0, ordinary_err, fatal_err};
    endfunction
    initial
    begin
        repeat (5000) @(posedge pclk);
        errors++;
        results();
    end
    initial
    begin
        rd = $urandom(32'h961AD5EC);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, `PSFB_OFF_MODE, 0);
        chk({err, rd}, 33'h0_0005_0000);
        apb(0, `PSFB_OFF_WDLIM, 0);
        chk(rd, 32'h0000_1770);
        apb(0, 8'h20, 0);
        chk({err, rd}, 33'h1_0000_0000);
        apb(1, `PSFB_OFF_MODE, 32'hFFFF_FFFF);
        chk({err, rd}, 33'h1_0000_0000);
        for (int i = 0; i < 24; i++)
        begin
            // First eight cover every debug run code
            mode_sel <= (i < 8) ? 2'h3 : 2'($urandom_range(3));
            dbg_run_sel <= (i < 8) ? 3'(i) : 3'($urandom_range(7));
            {fatal_err, ordinary_err, battery_low, fuse_blown} <= 4'($urandom_range(15));
            io_err <= (i % 3 == 0) ? 32'h0 : 32'h1 << $urandom_range(31);
            scan;
            apb(0, `PSFB_OFF_MODE, 0);
            chk({err, rd}, {1'b0, exp_mode(mode_sel, 0)});
            apb(0, `PSFB_OFF_DBGERR, 0);
            chk({err, rd}, {1'b0, exp_dbg()});
            apb(0, `PSFB_OFF_IOERR, 0);
            chk(rd, io_err);
        end
        apb(1, `PSFB_OFF_WDLIM, 2);
        apb(0, `PSFB_OFF_WDLIM, 0);
        chk({err, rd}, 33'h2);
        scan;
        repeat (30) @(posedge pclk);
        apb(0, `PSFB_OFF_DBGERR, 0);
        chk(rd[18], 1);
        apb(1, `PSFB_OFF_CTRL, 1);
        apb(0, `PSFB_OFF_DBGERR, 0);
        chk(rd[18], 0);
        scan;
        apb(0, `PSFB_OFF_MODE, 0);
        chk(rd, exp_mode(mode_sel, 0));
        // Last two scans 52 cycles apart; free divider phase gives 12 or 13 ms
        apb(0, `PSFB_OFF_SCANT, 0);
        chk({err, rd}, {1'b0, (rd == 32'h0000000D) ? 32'h0000000D : 32'h0000000C});
        results();
    end
endmodule // test_plc_status_flag_bank
